// >>> design/acp_pkg.sv
// Constants, register map and helpers of the converter core calibration controller.
// Assumes one 100 MHz clock; registers are word registers on a classic Wishbone slave.
// Summary of operation
// [R1] Foreground and background calibration modes only
// [R2] Foreground calibration forces mid-code on all channels
// [R3] Six cores, spares separate from output cores
// [R4] Foreground map: A-0, B-1, C-4, D-5
// [R5] Quad: core 2 spares 0/1, 3 spares 4/5
// [R6] Dual: core 2 alternately replaces cores 0, 1
// [R7] Single: core 2 replaces core 0
// [R8] Foreground calibration runs after reset; host waits
// [R9] Trigger source selected between pin and software
// [R10] Background mode keeps output samples flowing
// [R11] Calibrate offline core, swap in, repeat forever
// [R12] At most one core calibrating in background
// [R13] Host selects background: enable, pin off, soft
// [R14] Host programs switch delays 0x1f and 0x1e
// [R15] Readable writable factory trim per input, core
// [R16] Offset calibration once foreground, continuous background
// [R17] Low-power option sleeps spare until calibration due
// [R18] Swap timed by source and mux delays
`default_nettype none

package acp_pkg;

  // ***************************************************
  // Register indices (byte address is four times index)
  // ***************************************************
  localparam logic [7:0] IDX_CTRL = 8'h00;
  localparam logic [7:0] IDX_STATUS = 8'h01;
  localparam logic [7:0] IDX_OFS_BASE = 8'h40;
  localparam logic [7:0] IDX_GAIN_BASE = 8'h48;
  localparam logic [7:0] IDX_TERM_BASE = 8'h50;
  localparam logic [7:0] IDX_SRC_DLY = 8'h9a;
  localparam logic [7:0] IDX_MUX_DLY = 8'h9b;

  // ***************************************************
  // Control fields and reset values
  // ***************************************************
  localparam int CB_BG_EN = 0;
  localparam int CB_TRIG_SEL = 1;
  localparam int CB_SOFT_TRIG = 2;
  localparam int CB_FG_OS = 3;
  localparam int CB_BG_OS = 4;
  localparam int CB_LOW_POWER_BG_ENABLE = 5;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DLY_RST = 8'h00;
  localparam logic [7:0] TRIM_RST = 8'h80;

  // ***************************************************
  // Default cycle counts
  // ***************************************************
  localparam int FG_CAL_CYC = 8192;
  localparam int CORE_CAL_CYC = 8192;
  localparam int OFS_CAL_CYC = 4096;
  localparam int LP_SLEEP_CYC = 65536;

  typedef enum logic [2:0] {
    ST_FG = 3'b000,
    ST_IDLE = 3'b001,
    ST_SLEEP = 3'b010,
    ST_CAL = 3'b011,
    ST_SWAP = 3'b100
  } acp_state_t;

  // Core driving a channel in foreground mode
  function automatic logic [2:0] def_core(input int ch);
    case (ch)
      0: def_core = 3'h0;
      1: def_core = 3'h1;
      2: def_core = 3'h4;
      default: def_core = 3'h5;
    endcase
  endfunction

  // Cores present for a channel count
  function automatic logic [5:0] used_mask(input int nch);
    case (nch)
      1: used_mask = 6'h05;
      2: used_mask = 6'h07;
      default: used_mask = 6'h3f;
    endcase
  endfunction

endpackage : acp_pkg

`default_nettype wire

// >>> design/acp_swap_if.sv
// Swap timing handshake between the sequencer and the swap timer.
// Assumes both ends run on the same clock and clock enable.
`default_nettype none

interface acp_swap_if;
  logic req;
  logic [7:0] src_dly;
  logic [7:0] mux_dly;
  logic src_go;
  logic mux_go;
  logic done;
  logic busy;
  modport ctl (output req, src_dly, mux_dly, input src_go, mux_go, done, busy);
  modport tmr (input req, src_dly, mux_dly, output src_go, mux_go, done, busy);
endinterface : acp_swap_if

`default_nettype wire

// >>> design/acp_swap_timer.sv
// Swap timer: pulses core-source and output-mux switch after programmed delays.
// Assumes a request is only raised while the timer is not busy.
`default_nettype none

module acp_swap_timer
  import acp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Handshake
  acp_swap_if.tmr sw
);

  logic busy_r;
  logic [7:0] cnt_r;
  logic [7:0] src_r;
  logic [7:0] mux_r;
  logic [7:0] last;
  logic [8:0] elapsed_r;
  logic src_seen_r;
  logic mux_seen_r;

  assign last = (src_r > mux_r) ? src_r : mux_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      cnt_r <= 8'h00;
      src_r <= 8'h00;
      mux_r <= 8'h00;
    end else if (ce) begin
      if (sw.req && !busy_r) begin
        busy_r <= 1'b1;
        cnt_r <= 8'h00;
        src_r <= sw.src_dly;
        mux_r <= sw.mux_dly;
      end else if (busy_r && cnt_r == last) begin
        busy_r <= 1'b0;
      end else if (busy_r) begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

  assign sw.src_go = busy_r && ce && cnt_r == src_r; // R18
  assign sw.mux_go = busy_r && ce && cnt_r == mux_r; // R18
  assign sw.done = busy_r && ce && cnt_r == last;
  assign sw.busy = busy_r;

  // ***************************************************
  // Assertions
  // ***************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      elapsed_r <= 9'h000;
      src_seen_r <= 1'b0;
      mux_seen_r <= 1'b0;
    end else if (ce) begin
      if (sw.req && !busy_r) begin
        elapsed_r <= 9'h000;
        src_seen_r <= 1'b0;
        mux_seen_r <= 1'b0;
      end else begin
        elapsed_r <= elapsed_r + 9'h001;
        if (sw.src_go) src_seen_r <= 1'b1;
        if (sw.mux_go) mux_seen_r <= 1'b1;
      end
    end
  end

  a_src_delay: assert property (@(posedge clk) disable iff (!rst_n) // R18
    sw.src_go |-> elapsed_r == {1'b0, src_r})
    else $error("core source switch off its delay");
  a_mux_delay: assert property (@(posedge clk) disable iff (!rst_n) // R18
    sw.mux_go |-> elapsed_r == {1'b0, mux_r})
    else $error("output mux switch off its delay");
  a_both_switched: assert property (@(posedge clk) disable iff (!rst_n) // R18
    sw.done |-> (src_seen_r || sw.src_go) && (mux_seen_r || sw.mux_go))
    else $error("swap ended without both switches");
  c_swap_done: cover property (@(posedge clk) disable iff (!rst_n) sw.done);

endmodule : acp_swap_timer

`default_nettype wire

// >>> design/acp_cal_ctrl.sv
// Calibration sequencer for six converter cores with a Wishbone register file.
// Assumes core samples arrive synchronous to CLK_SYS; Wishbone classic single cycles.
//
// The Wishbone register port was decided locally.
`default_nettype none

module acp_cal_ctrl
  import acp_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int DW = 12,
  parameter int FG_CYC = FG_CAL_CYC,
  parameter int CAL_CYC = CORE_CAL_CYC,
  parameter int OFS_CYC = OFS_CAL_CYC,
  parameter int SLEEP_CYC = LP_SLEEP_CYC
) (
  // Clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [9:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Trigger pin
  input wire logic CAL_TRIGGER_PIN,
  // Core samples and channel outputs
  input wire logic [6*DW-1:0] CORE_DATA,
  output logic [4*DW-1:0] CH_DATA,
  // Core control
  output logic [5:0] CORE_CAL_EN,
  output logic [5:0] CORE_PWR_EN,
  output logic [11:0] CORE_INPUT_SEL,
  output logic OFFSET_CAL_ACTIVE,
  output logic FG_CAL_BUSY,
  // Trim values
  output logic [47:0] TRIM_OFFSET,
  output logic [47:0] TRIM_GAIN,
  output logic [31:0] TRIM_TERM
);

  localparam logic [5:0] USED = used_mask(NUM_CH);
  localparam logic [19:0] FG_LD = 20'(FG_CYC - 1);
  localparam logic [19:0] FG_OS_LD = 20'(FG_CYC + OFS_CYC - 1);
  localparam logic [19:0] CAL_LD = 20'(CAL_CYC - 1);
  localparam logic [19:0] FOREGROUND_OFFSET_CAL_ENABLE_LD = 20'(CAL_CYC + OFS_CYC - 1);
  localparam logic [19:0] SLEEP_LD = 20'(SLEEP_CYC - 1);

  // ***************************************************
  // Registers and state
  // ***************************************************
  logic [7:0] ctrl_r;
  logic [7:0] src_dly_r;
  logic [7:0] mux_dly_r;
  logic [7:0] ofs_r [6];
  logic [7:0] gain_r [6];
  logic [7:0] term_r [4];
  acp_state_t state_r;
  acp_state_t state_nxt;
  logic [19:0] cnt_r;
  logic fg_done_r;
  logic trig_q_r;
  logic grp_r;
  logic [2:0] ch_core_r [4];
  logic [2:0] off_core_r [2];
  logic nxt_ch_r [2];
  logic [1:0] core_src_r [6];
  logic [2:0] victim_r;
  logic ack_r;
  logic [31:0] rdat_r;

  acp_swap_if sw ();

  acp_swap_timer u_timer (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .ce(CLK_EN),
    .sw(sw.tmr)
  );

  // ***************************************************
  // Trigger and mode decode
  // ***************************************************
  logic trig;
  logic fg_start;
  logic bg_go;
  logic [7:0] idx;
  logic wb_req;
  logic wr;
  logic [1:0] vch;

  assign trig = ctrl_r[CB_TRIG_SEL] ? CAL_TRIGGER_PIN : ctrl_r[CB_SOFT_TRIG]; // R9
  assign bg_go = ctrl_r[CB_BG_EN] && !ctrl_r[CB_TRIG_SEL] && ctrl_r[CB_SOFT_TRIG]; // R13
  assign fg_start = trig && !trig_q_r && !bg_go; // R9
  assign idx = WB_ADR_I[9:2];
  assign wb_req = WB_CYC_I && WB_STB_I && !ack_r;
  assign wr = WB_CYC_I && WB_STB_I && ack_r && WB_WE_I && WB_SEL_I[0];
  assign vch = {grp_r, nxt_ch_r[grp_r]};

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) trig_q_r <= 1'b0;
    else if (CLK_EN) trig_q_r <= trig;
  end

  // ***************************************************
  // Sequencer
  // ***************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_FG: if (cnt_r == 20'h0) state_nxt = ST_IDLE;
      ST_IDLE: begin
        if (fg_start) state_nxt = ST_FG;
        else if (bg_go) state_nxt = ctrl_r[CB_LOW_POWER_BG_ENABLE] ? ST_SLEEP : ST_CAL; // R17
      end
      ST_SLEEP: begin
        if (!bg_go) state_nxt = ST_IDLE;
        else if (cnt_r == 20'h0) state_nxt = ST_CAL; // R17
      end
      ST_CAL: begin
        if (!bg_go) state_nxt = ST_IDLE;
        else if (cnt_r == 20'h0) state_nxt = ST_SWAP; // R11
      end
      ST_SWAP: begin
        if (sw.done) begin
          if (!bg_go) state_nxt = ST_IDLE;
          else state_nxt = ctrl_r[CB_LOW_POWER_BG_ENABLE] ? ST_SLEEP : ST_CAL; // R11
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= ST_FG; // R8
      cnt_r <= FG_LD;
      fg_done_r <= 1'b0;
    end else if (CLK_EN) begin
      state_r <= state_nxt;
      if (state_nxt == ST_FG && state_r != ST_FG) begin
        cnt_r <= ctrl_r[CB_FG_OS] ? FG_OS_LD : FG_LD; // R16
      end else if (state_nxt == ST_SLEEP && state_r != ST_SLEEP) begin
        cnt_r <= SLEEP_LD;
      end else if (state_nxt == ST_CAL && state_r != ST_CAL) begin
        cnt_r <= ctrl_r[CB_BG_OS] ? FOREGROUND_OFFSET_CAL_ENABLE_LD : CAL_LD; // R16
      end else if (cnt_r != 20'h0) begin
        cnt_r <= cnt_r - 20'h1;
      end
      if (state_r == ST_FG) fg_done_r <= (state_nxt != ST_FG);
    end
  end

  // Group alternates between swaps on the quad part only
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) grp_r <= 1'b0;
    else if (CLK_EN) begin
      if (state_r == ST_FG) grp_r <= 1'b0;
      else if (sw.done && NUM_CH == 4) grp_r <= !grp_r; // R12
    end
  end

  // ***************************************************
  // Core rotation
  // ***************************************************
  assign sw.req = (state_r == ST_CAL) && (state_nxt == ST_SWAP);
  assign sw.src_dly = src_dly_r;
  assign sw.mux_dly = mux_dly_r;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int c = 0; c < 4; c++) ch_core_r[c] <= def_core(c); // R4
      off_core_r[0] <= 3'h2; // R5
      off_core_r[1] <= 3'h3; // R5
      nxt_ch_r[0] <= 1'b0;
      nxt_ch_r[1] <= 1'b0;
      victim_r <= 3'h0;
      core_src_r[0] <= 2'h0; // R4
      core_src_r[1] <= 2'h1; // R4
      core_src_r[2] <= 2'h0;
      core_src_r[3] <= 2'h2;
      core_src_r[4] <= 2'h2; // R4
      core_src_r[5] <= 2'h3; // R4
    end else if (CLK_EN) begin
      if (state_r == ST_FG) begin
        for (int c = 0; c < 4; c++) ch_core_r[c] <= def_core(c); // R4
        off_core_r[0] <= 3'h2; // R6
        off_core_r[1] <= 3'h3;
        nxt_ch_r[0] <= 1'b0;
        nxt_ch_r[1] <= 1'b0;
        core_src_r[0] <= 2'd0;
        core_src_r[1] <= 2'd1;
        core_src_r[4] <= 2'd2;
        core_src_r[5] <= 2'd3;
      end else begin
        if (sw.req) victim_r <= ch_core_r[vch];
        if (sw.src_go) core_src_r[off_core_r[grp_r]] <= vch; // R18
        if (sw.mux_go) ch_core_r[vch] <= off_core_r[grp_r]; // R18
        if (sw.done) begin
          off_core_r[grp_r] <= victim_r; // R11
          if (NUM_CH > 1) nxt_ch_r[grp_r] <= !nxt_ch_r[grp_r]; // R6 R7
        end
      end
    end
  end

  // ***************************************************
  // Outputs to cores and channels
  // ***************************************************
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      CH_DATA <= '0;
      CORE_CAL_EN <= USED;
      CORE_PWR_EN <= USED;
      OFFSET_CAL_ACTIVE <= 1'b0;
    end else if (CLK_EN) begin
      for (int c = 0; c < 4; c++) begin
        if (state_r == ST_FG || c >= NUM_CH) CH_DATA[c*DW +: DW] <= '0; // R2
        else CH_DATA[c*DW +: DW] <= CORE_DATA[ch_core_r[c]*DW +: DW]; // R10
      end
      CORE_CAL_EN <= '0;
      if (state_nxt == ST_FG) CORE_CAL_EN <= USED; // R1
      else if (state_nxt == ST_CAL) CORE_CAL_EN[off_core_r[grp_r]] <= 1'b1; // R12
      CORE_PWR_EN <= USED; // R3
      if (ctrl_r[CB_LOW_POWER_BG_ENABLE] && state_nxt != ST_FG) begin
        for (int g = 0; g < 2; g++) begin
          if (!(state_nxt == ST_CAL && grp_r == 1'(g))) CORE_PWR_EN[off_core_r[g]] <= 1'b0; // R17
        end
      end
      OFFSET_CAL_ACTIVE <= (state_nxt == ST_FG && ctrl_r[CB_FG_OS])
        || (state_nxt == ST_CAL && ctrl_r[CB_BG_OS]); // R16
    end
  end

  always_comb begin
    for (int k = 0; k < 6; k++) CORE_INPUT_SEL[k*2 +: 2] = core_src_r[k];
    for (int k = 0; k < 6; k++) TRIM_OFFSET[k*8 +: 8] = ofs_r[k];
    for (int k = 0; k < 6; k++) TRIM_GAIN[k*8 +: 8] = gain_r[k];
    for (int k = 0; k < 4; k++) TRIM_TERM[k*8 +: 8] = term_r[k];
  end
  assign FG_CAL_BUSY = (state_r == ST_FG);

  // ***************************************************
  // Wishbone register file
  // ***************************************************
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_r <= CTRL_RST;
      src_dly_r <= DLY_RST;
      mux_dly_r <= DLY_RST;
      for (int k = 0; k < 6; k++) ofs_r[k] <= TRIM_RST; // R15
      for (int k = 0; k < 6; k++) gain_r[k] <= TRIM_RST;
      for (int k = 0; k < 4; k++) term_r[k] <= TRIM_RST;
    end else if (CLK_EN && wr) begin
      if (idx == IDX_CTRL) ctrl_r <= WB_DAT_I[7:0];
      if (idx == IDX_SRC_DLY) src_dly_r <= WB_DAT_I[7:0]; // R14
      if (idx == IDX_MUX_DLY) mux_dly_r <= WB_DAT_I[7:0]; // R14
      for (int k = 0; k < 6; k++) begin
        if (idx == IDX_OFS_BASE + 8'(k)) ofs_r[k] <= WB_DAT_I[7:0]; // R15
        if (idx == IDX_GAIN_BASE + 8'(k)) gain_r[k] <= WB_DAT_I[7:0]; // R15
      end
      for (int k = 0; k < 4; k++) begin
        if (idx == IDX_TERM_BASE + 8'(k)) term_r[k] <= WB_DAT_I[7:0]; // R15
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0;
    end else if (CLK_EN) begin
      ack_r <= wb_req;
      rdat_r <= 32'h0;
      if (wb_req) begin
        if (idx == IDX_CTRL) rdat_r[7:0] <= ctrl_r;
        if (idx == IDX_STATUS) begin
          rdat_r <= {23'h000000, sw.busy, off_core_r[grp_r], state_r, fg_done_r,
            (state_r != ST_FG && state_r != ST_IDLE)};
        end
        if (idx == IDX_SRC_DLY) rdat_r[7:0] <= src_dly_r;
        if (idx == IDX_MUX_DLY) rdat_r[7:0] <= mux_dly_r;
        for (int k = 0; k < 6; k++) begin
          if (idx == IDX_OFS_BASE + 8'(k)) rdat_r[7:0] <= ofs_r[k];
          if (idx == IDX_GAIN_BASE + 8'(k)) rdat_r[7:0] <= gain_r[k];
        end
        for (int k = 0; k < 4; k++) begin
          if (idx == IDX_TERM_BASE + 8'(k)) rdat_r[7:0] <= term_r[k];
        end
      end
    end
  end
  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = rdat_r;

  // ***************************************************
  // Assertions
  // ***************************************************
  a_midcode_fg: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R2
    CLK_EN && state_r == ST_FG |=> CH_DATA == '0)
    else $error("channel data not mid-code in foreground calibration");
  a_one_cal_core: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R12
    state_r != ST_FG && $past(state_r) != ST_FG |-> $onehot0(CORE_CAL_EN))
    else $error("more than one core calibrating in background");
  a_fg_all_cores: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R1
    CLK_EN && state_nxt == ST_FG |=> CORE_CAL_EN == USED)
    else $error("foreground calibration missing cores");
  a_fg_map: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R4
    CLK_EN && state_r == ST_FG |=> ch_core_r[0] == 3'h0 && ch_core_r[1] == 3'h1
      && ch_core_r[2] == 3'h4 && ch_core_r[3] == 3'h5)
    else $error("foreground core map wrong");
  a_spare_group: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R5
    off_core_r[0] <= 3'h2 && off_core_r[1] >= 3'h3)
    else $error("spare core left its group");
  a_trig_fg: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R9
    CLK_EN && state_r == ST_IDLE && fg_start |=> state_r == ST_FG ##1 FG_CAL_BUSY)
    else $error("trigger did not start foreground calibration");
  a_rotate: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R11
    sw.done && state_r == ST_SWAP |=> off_core_r[$past(grp_r)] == $past(victim_r))
    else $error("swapped core did not go offline");
  a_powerup_fg: assert property (@(posedge CLK_SYS) // R8
    $rose(RESET_N) |-> state_r == ST_FG && FG_CAL_BUSY)
    else $error("no foreground calibration after reset");
  a_cal_powered: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R17
    (CORE_CAL_EN & ~CORE_PWR_EN) == 6'h00)
    else $error("calibrating core is powered down");
  a_ofs_bg: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R16
    CLK_EN && state_nxt == ST_CAL && ctrl_r[CB_BG_OS] |=> OFFSET_CAL_ACTIVE)
    else $error("offset calibration idle in background");
  a_ack_pulse: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    CLK_EN && WB_ACK_O |=> !WB_ACK_O)
    else $error("bus acknowledge held longer than one cycle");
  c_grp_swap: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) sw.done && grp_r);
  c_fg_done: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) $fell(FG_CAL_BUSY));
  c_bg_cal: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) state_r == ST_CAL);
  c_lp_sleep: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) state_r == ST_SLEEP);

endmodule : acp_cal_ctrl

`default_nettype wire

// >>> design/acp_cal_ctrl_unused_note.sv
// Spare file of the calibration controller: holds no code.
// Assumes nothing of its surroundings.
`default_nettype none
`default_nettype wire

// >>> sim/acp_core_src.sv
// Analog source model: one distinct sample stream per core.
// Assumes cores sample on the rising edge of the system clock.
`default_nettype none

module acp_core_src #(
  parameter int DW = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Core samples
  output logic [6*DW-1:0] core_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // Top nibble names the core, low bits move every cycle
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      core_data[k*DW+:DW] = DW'({4'(k + 1), cnt_r});
    end
  end
endmodule // acp_core_src

`default_nettype wire

// >>> sim/adc_core_calibration_control_tb_top.sv
// Testbench: register, trigger and rotation sequences for the sequencer.
// Assumes the design package, interface and modules are compiled first.
`default_nettype none

module adc_core_calibration_control_tb_top import acp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FGC = 20;
  localparam int CLC = 16;
  localparam int OFC = 8;
  localparam int SLC = 12;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic pin = 1'b0;
  logic ce = 1'b1;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [71:0] core;
  logic [47:0] ch;
  logic [5:0] cal_en;
  logic [5:0] pwr_en;
  logic [11:0] isel;
  logic ofs_act;
  logic busy;
  logic [47:0] t_ofs;
  logic [47:0] t_gain;
  logic [31:0] t_term;
  logic [5:0] seen;
  logic pdn;
  int gaps;
  int multi;
  int moves;
  int grp;
  int errors = 0;
  int checked = 0;

  always #5 clk = ~clk;

  acp_core_src #(.DW(12)) src_u (.clk(clk), .rst_n(rst_n), .core_data(core));

  acp_cal_ctrl #(.NUM_CH(4), .DW(12), .FG_CYC(FGC), .CAL_CYC(CLC),
    .OFS_CYC(OFC), .SLEEP_CYC(SLC)) dut_u (
    .CLK_SYS(clk), .RESET_N(rst_n), .CLK_EN(ce),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .CAL_TRIGGER_PIN(pin), .CORE_DATA(core), .CH_DATA(ch),
    .CORE_CAL_EN(cal_en), .CORE_PWR_EN(pwr_en), .CORE_INPUT_SEL(isel),
    .OFFSET_CAL_ACTIVE(ofs_act), .FG_CAL_BUSY(busy),
    .TRIM_OFFSET(t_ofs), .TRIM_GAIN(t_gain), .TRIM_TERM(t_term));

  // ********
  // Tasks
  // ********
  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) chk("wb_ack", 48'h1, 48'h0);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, idx, d, q);
  endtask

  task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    wb(1'b0, idx, 8'h00, q);
    chk(nm, exp, q);
  endtask

  // Length of one foreground run, with mid-code and offset activity
  task automatic fg_len(output int n, output int bad, output logic so);
    int w;
    n = 0;
    bad = 0;
    so = 1'b0;
    w = 0;
    while (busy !== 1'b1 && w < 30) begin
      @(negedge clk);
      w++;
    end
    while (busy === 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
      if (ch !== 48'h0) bad++;
      if (ofs_act === 1'b1) so = 1'b1;
    end
  endtask

  // Watch the rotation for a number of cycles
  task automatic bg_run(input int cn);
    logic [3:0] last;
    logic [3:0] id;
    seen = 6'h00;
    pdn = 1'b0;
    gaps = 0;
    multi = 0;
    moves = 0;
    grp = 0;
    last = ch[11:8];
    repeat (cn) begin
      @(negedge clk);
      seen |= cal_en;
      if ($countones(cal_en) > 1) multi++;
      if (busy !== 1'b0) gaps++;
      if (pwr_en !== 6'h3f) pdn = 1'b1;
      if (ch[11:8] !== last) moves++;
      last = ch[11:8];
      for (int c = 0; c < 4; c++) begin
        id = ch[c*12+8+:4];
        if (id === 4'h0 || id > 4'h6) gaps++;
        if ((c < 2) != (id <= 4'h3)) grp++;
      end
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #300000;
    errors++;
    tally_and_finish();
  end

  // ********
  // Tests
  // ********
  initial begin
    int n0;
    int n1;
    int n2;
    int bad;
    logic so;
    logic [7:0] q;
    logic [47:0] snap;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("boot_busy", 48'h1, busy);
    fg_len(n0, bad, so);
    chk("boot_mid", 48'h0, bad);
    @(negedge clk);
    chk("fg_map", 48'h6521, {ch[47:44], ch[35:32], ch[23:20], ch[11:8]});
    chk("fg_sel", 48'he4, {isel[11:8], isel[3:0]});
    $display("test boot done");
    rd("ctrl_rst", IDX_CTRL, 8'h00);
    rd("src_rst", IDX_SRC_DLY, 8'h00);
    rd("trim_rst", IDX_GAIN_BASE + 8'h05, 8'h80);
    for (int k = 0; k < 6; k++) begin
      wr(IDX_OFS_BASE + 8'(k), 8'h10 + 8'(k));
      wr(IDX_GAIN_BASE + 8'(k), 8'h20 + 8'(k));
    end
    for (int k = 0; k < 4; k++) wr(IDX_TERM_BASE + 8'(k), 8'h30 + 8'(k));
    for (int k = 0; k < 6; k++) begin
      rd("ofs_trim", IDX_OFS_BASE + 8'(k), 8'h10 + 8'(k));
      rd("gain_trim", IDX_GAIN_BASE + 8'(k), 8'h20 + 8'(k));
      chk("ofs_out", 8'h10 + 8'(k), t_ofs[k*8+:8]);
      chk("gain_out", 8'h20 + 8'(k), t_gain[k*8+:8]);
    end
    for (int k = 0; k < 4; k++) chk("term_out", 8'h30 + 8'(k), t_term[k*8+:8]);
    wr(IDX_SRC_DLY, 8'h1f);
    wr(IDX_MUX_DLY, 8'h1e);
    rd("src_dly", IDX_SRC_DLY, 8'h1f);
    rd("mux_dly", IDX_MUX_DLY, 8'h1e);
    wr(8'h7f, 8'h5a);
    rd("unmapped", 8'h7f, 8'h00);
    $display("test registers done");
    wr(IDX_CTRL, 8'h04);
    fg_len(n0, bad, so);
    chk("soft_run", 48'h1, n0 > 0);
    chk("soft_mid", 48'h0, bad);
    wr(IDX_CTRL, 8'h00);
    wr(IDX_CTRL, 8'h0c);
    fg_len(n1, bad, so);
    chk("ofs_extra", OFC, n1 - n0);
    chk("ofs_active", 48'h1, so);
    wr(IDX_CTRL, 8'h02);
    wr(IDX_CTRL, 8'h06);
    repeat (5) @(negedge clk);
    chk("soft_ignored", 48'h0, busy);
    @(posedge clk);
    pin <= 1'b1;
    fg_len(n2, bad, so);
    @(posedge clk);
    pin <= 1'b0;
    chk("pin_run", n0, n2);
    $display("test triggers done");
    wr(IDX_CTRL, 8'h00);
    wr(IDX_CTRL, 8'h05);
    wb(1'b0, IDX_STATUS, 8'h00, q);
    chk("bg_status", 48'h1, q[0]);
    bg_run(1000);
    chk("bg_gap", 48'h0, gaps);
    chk("bg_one", 48'h0, multi);
    chk("bg_group", 48'h0, grp);
    chk("bg_all", 48'h3f, seen);
    chk("bg_moves", 48'h1, moves > 0);
    @(posedge clk);
    ce <= 1'b0;
    @(negedge clk);
    snap = ch;
    repeat (10) @(negedge clk);
    chk("freeze", snap, ch);
    @(posedge clk);
    ce <= 1'b1;
    $display("test background done");
    wr(IDX_CTRL, 8'h00);
    wr(IDX_CTRL, 8'h35);
    bg_run(1000);
    chk("lp_sleep", 48'h1, pdn);
    chk("lp_one", 48'h0, multi);
    chk("lp_gap", 48'h0, gaps);
    wr(IDX_CTRL, 8'h00);
    $display("test low power done");
    tally_and_finish();
  end
endmodule // adc_core_calibration_control_tb_top

`default_nettype wire
